// ===== rdp_bus_asserts.sv
/*
  Checker for the register link between the CPU end and the radio end.
  Assumes one clock, a synchronous active-high reset and the rdp_pkg map.
*/
`default_nettype none
module rdp_bus_asserts
    import rdp_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic data_req,
    input wire logic event_irq
);
    logic [7:0] mask_sh_r;
    logic [7:0] mask_sh_nxt;
    logic mapped;

    // Shadow of the mask, so readback and interrupt can be judged
    always_comb
    begin
        mask_sh_nxt = mask_sh_r;
        if (wr && addr == ADDR_EVENT_MASK)
        begin
            mask_sh_nxt = wdata;
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            mask_sh_r <= 8'h00;
        end
        else
        begin
            mask_sh_r <= mask_sh_nxt;
        end
    end
    // The strobe place is mapped too, its read value is left open
    assign mapped = addr inside {ADDR_EVENT_MASK, ADDR_EVENT_FLAGS,
        ADDR_DATA_BYTE, ADDR_STROBE, ADDR_MODEM_CFG3, ADDR_MODEM_CFG4};

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    rd_answer_a: assert property (rd |=> rvalid)
        else $error("read got no answer");
    rvalid_cause_a: assert property (rvalid |-> $past(rd))
        else $error("answer without read");
    rdata_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without read");
    mask_back_a: assert property (
        rd && !wr && addr == ADDR_EVENT_MASK |=> rdata == mask_sh_r)
        else $error("mask readback wrong");
    unmapped_zero_a: assert property (rd && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    irq_mask_a: assert property (event_irq |-> mask_sh_r != 8'h00)
        else $error("radio flag with empty mask");
    reset_quiet_a: assert property (
        $fell(sys_rst_i) |-> !rvalid && !data_req && !event_irq)
        else $error("outputs busy after reset");
    data_write_a: assert property (
        wr && !rd && addr == ADDR_DATA_BYTE && data_req |=> !data_req)
        else $error("data byte still requested after write");
    idle_quiet_a: assert property (
        wr && addr == ADDR_STROBE && wdata == STROBE_GO_IDLE
        |=> !data_req [*2])
        else $error("data request after go idle");

    // Main scenarios
    cover property (rd ##1 rvalid);
    cover property (wr && addr == ADDR_STROBE && wdata == STROBE_TRANSMIT);
    cover property (event_irq);
endmodule : rdp_bus_asserts
`default_nettype wire

// ===== rdp_cpu_port.sv
/*
  CPU/DMA end: runs user register commands and moves bytes between
  two-entry buffers and the radio data byte on its data request.
  Assumes the radio end sits on the same clock across rdp_if.
*/
`default_nettype none
module rdp_cpu_port (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    rdp_if.cpu bus,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic resp_valid_o,
    output logic [7:0] resp_data_o,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [7:0] rx_data_o,
    output logic radio_irq_o
);
    import rdp_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_CMD_RD, HS_RX_RD} rdp_hst_t;
    typedef enum logic [1:0] {DIR_NONE, DIR_RX, DIR_TX} rdp_dir_t;

    rdp_hst_t st_r, st_nxt;
    rdp_dir_t dir_r, dir_nxt;
    logic [7:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
    logic wr_r, wr_nxt, rd_r, rd_nxt;
    logic cmd_ready_r, resp_valid_r, resp_valid_nxt;
    logic [7:0] resp_data_r, resp_data_nxt;
    logic [7:0] tx_mem_r [2], tx_mem_nxt [2];
    logic [7:0] rx_mem_r [2], rx_mem_nxt [2];
    logic tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
    logic tx_wp_nxt, tx_rp_nxt, rx_wp_nxt, rx_rp_nxt;
    logic [1:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
    logic tx_ready_r, rx_valid_r, irq_r;
    logic [7:0] rx_data_r, rx_data_nxt;
    logic tx_push, tx_pop, rx_push, rx_pop;

    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;
    assign bus.wr = wr_r;
    assign bus.rd = rd_r;
    assign cmd_ready_o = cmd_ready_r;
    assign resp_valid_o = resp_valid_r;
    assign resp_data_o = resp_data_r;
    assign tx_ready_o = tx_ready_r;
    assign rx_valid_o = rx_valid_r;
    assign rx_data_o = rx_data_r;
    assign radio_irq_o = irq_r;

    // User commands take priority; the mover runs only when bus is free
    always_comb
    begin
        st_nxt = st_r;
        dir_nxt = dir_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        resp_valid_nxt = 1'b0;
        resp_data_nxt = resp_data_r;
        tx_mem_nxt = tx_mem_r;
        rx_mem_nxt = rx_mem_r;
        tx_push = tx_valid_i && tx_ready_r;
        rx_pop = rx_valid_r && rx_ready_i;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        if (tx_push)
            tx_mem_nxt[tx_wp_r] = tx_data_i;
        unique case (st_r)
            HS_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    addr_nxt = cmd_addr_i;
                    wdata_nxt = cmd_wdata_i;
                    if (cmd_write_i)
                    begin
                        wr_nxt = 1'b1;
                        if (cmd_addr_i == ADDR_STROBE)
                        begin
                            if (cmd_wdata_i == STROBE_TRANSMIT)
                                dir_nxt = DIR_TX;
                            else if (cmd_wdata_i == STROBE_RECEIVE)
                                dir_nxt = DIR_RX;
                            else if (cmd_wdata_i == STROBE_GO_IDLE)
                                dir_nxt = DIR_NONE;
                        end
                    end
                    else
                    begin
                        rd_nxt = 1'b1;
                        st_nxt = HS_CMD_RD;
                    end
                end
                // A full receive buffer stalls reads, so the radio overflows
                else if (dir_r == DIR_RX && bus.data_req && rx_cnt_r != 2'd2)
                begin
                    addr_nxt = ADDR_DATA_BYTE;
                    rd_nxt = 1'b1;
                    st_nxt = HS_RX_RD;
                end
                // data_req lags a write by a cycle
                else if (dir_r == DIR_TX && bus.data_req && !wr_r &&
                         tx_cnt_r != 2'd0)
                begin
                    addr_nxt = ADDR_DATA_BYTE;
                    wdata_nxt = tx_mem_r[tx_rp_r];
                    wr_nxt = 1'b1;
                    tx_pop = 1'b1;
                end
            end
            HS_CMD_RD:
            begin
                if (bus.rvalid)
                begin
                    resp_valid_nxt = 1'b1;
                    resp_data_nxt = bus.rdata;
                    st_nxt = HS_IDLE;
                end
            end
            HS_RX_RD:
            begin
                if (bus.rvalid)
                begin
                    rx_push = 1'b1;
                    rx_mem_nxt[rx_wp_r] = bus.rdata;
                    st_nxt = HS_IDLE;
                end
            end
        endcase
        tx_wp_nxt = tx_wp_r ^ tx_push;
        tx_rp_nxt = tx_rp_r ^ tx_pop;
        rx_wp_nxt = rx_wp_r ^ rx_push;
        rx_rp_nxt = rx_rp_r ^ rx_pop;
        tx_cnt_nxt = tx_cnt_r + 2'(tx_push) - 2'(tx_pop);
        rx_cnt_nxt = rx_cnt_r + 2'(rx_push) - 2'(rx_pop);
        rx_data_nxt = rx_mem_nxt[rx_rp_nxt];
    end

    // Registers for the host end
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= HS_IDLE;
            dir_r <= DIR_NONE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cmd_ready_r <= 1'b0;
            resp_valid_r <= 1'b0;
            resp_data_r <= 8'h00;
            tx_mem_r <= '{default: 8'h00};
            rx_mem_r <= '{default: 8'h00};
            {tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r} <= 4'h0;
            tx_cnt_r <= 2'd0;
            rx_cnt_r <= 2'd0;
            tx_ready_r <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_data_r <= 8'h00;
            irq_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            dir_r <= dir_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cmd_ready_r <= (st_nxt == HS_IDLE);
            resp_valid_r <= resp_valid_nxt;
            resp_data_r <= resp_data_nxt;
            tx_mem_r <= tx_mem_nxt;
            rx_mem_r <= rx_mem_nxt;
            {tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r} <=
                {tx_wp_nxt, tx_rp_nxt, rx_wp_nxt, rx_rp_nxt};
            tx_cnt_r <= tx_cnt_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tx_ready_r <= (tx_cnt_nxt != 2'd2);
            rx_valid_r <= (rx_cnt_nxt != 2'd0);
            rx_data_r <= rx_data_nxt;
            irq_r <= bus.event_irq;
        end
    end
endmodule : rdp_cpu_port
`default_nettype wire

// ===== rdp_if.sv
/*
  Register bus between the CPU/DMA end and the radio port end.
  Assumes both ends run on the same system clock.
*/
`default_nettype none
interface rdp_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic rvalid;
    logic data_req;
    logic event_irq;

    modport dev (
        input addr, wdata, wr, rd,
        output rdata, rvalid, data_req, event_irq
    );
    modport cpu (
        output addr, wdata, wr, rd,
        input rdata, rvalid, data_req, event_irq
    );
endinterface : rdp_if
`default_nettype wire

// ===== rdp_pkg.sv
/*
  Shared constants and types for the radio event and data port.
  Assumes an 8-bit register bus with an 8-bit address, one access per cycle.
*/
`default_nettype none
package rdp_pkg;
    // Register addresses on the register bus
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h91;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'he9;
    localparam logic [7:0] ADDR_DATA_BYTE = 8'hd9;
    localparam logic [7:0] ADDR_STROBE = 8'he1;
    localparam logic [7:0] ADDR_MODEM_CFG3 = 8'ha3;
    localparam logic [7:0] ADDR_MODEM_CFG4 = 8'ha4;
    // Reset values
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
    localparam logic [7:0] RST_DATA_BYTE = 8'h00;
    localparam logic [7:0] RST_MODEM_CFG3 = 8'h00;
    localparam logic [7:0] RST_MODEM_CFG4 = 8'h00;
    // Event flag and mask bit positions
    localparam int FLAG_TX_UNDERFLOW = 7;
    localparam int FLAG_RX_OVERFLOW = 6;
    localparam int FLAG_RX_TIMEOUT = 5;
    localparam int FLAG_PACKET_DONE = 4;
    localparam int FLAG_CARRIER_SENSE = 3;
    localparam int FLAG_PREAMBLE_QUALITY = 2;
    localparam int FLAG_CLEAR_CHANNEL = 1;
    localparam int FLAG_SYNC_DETECTED = 0;
    // Field positions in modem_config_four
    localparam int BW_EXP_MSB = 7;
    localparam int BW_EXP_LSB = 6;
    localparam int BW_MANT_MSB = 5;
    localparam int BW_MANT_LSB = 4;
    localparam int RATE_EXP_MSB = 3;
    localparam int RATE_EXP_LSB = 0;
    // Command strobe codes
    localparam logic [7:0] STROBE_RECEIVE = 8'h02;
    localparam logic [7:0] STROBE_TRANSMIT = 8'h03;
    localparam logic [7:0] STROBE_GO_IDLE = 8'h04;
    // Rate and filter formula constants
    localparam logic [8:0] RATE_MANT_BASE = 9'h100;
    localparam int RATE_FRAC_BITS = 28;
    localparam logic [8:0] BW_MANT_BASE = 9'h004;
    localparam int BW_DIV_SHIFT = 3;
    // Radio operating state
    typedef enum logic [2:0] {
        RDP_IDLE,
        RDP_RX,
        RDP_TX,
        RDP_RX_OVERFLOW,
        RDP_TX_UNDERFLOW
    } rdp_mode_t;
endpackage : rdp_pkg
`default_nettype wire

// ===== rdp_radio_port.sv
/*
  Radio end: event flags and mask, one-byte data register, command
  strobes, rate and channel filter timing.
  Assumes modem status and byte strobes come from logic on mclk_i.
*/
// Operation
// - Eight event flags at fixed bit positions
// - Flags reset zero, cleared by writing zero
// - Mask register, eight read/write enable bits
// - Packet done also set with overflow/underflow
// - One shared data byte acts as FIFO
// - Unread byte overwritten: overflow, set two flags
// - Missing transmit byte: underflow, set two flags
// - No byte yet: keep preamble, no underflow
// - Go-idle strobe leaves error states
// - Data byte not kept through deep sleep
// - DMA moves bytes on data request trigger
// - Symbol rate from rate mantissa and exponent
// - Software avoids mantissa rounding to 256
// - Filter bandwidth from mantissa and exponent
// - Signal uses at most 80% bandwidth
// - Masked pending flag raises CPU radio flag
// - Flags set on rising status edge
// - Data request when byte readable or writable
// - No transmit request before transmit strobe
`default_nettype none
module rdp_radio_port (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    rdp_if.dev bus,
    input wire logic [5:0] modem_status_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic tx_byte_req_i,
    output logic tx_byte_valid_o,
    output logic [7:0] tx_byte_o,
    output logic tx_preamble_o,
    output rdp_pkg::rdp_mode_t mode_o,
    output logic symbol_tick_o,
    output logic filter_tick_o
);
    import rdp_pkg::*;

    rdp_mode_t st_r, st_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] data_r, data_nxt;
    logic full_r, full_nxt;
    logic started_r, started_nxt;
    logic [7:0] cfg3_r, cfg3_nxt;
    logic [7:0] cfg4_r, cfg4_nxt;
    logic [5:0] prev_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r;
    logic data_req_r, data_req_nxt;
    logic irq_r, irq_nxt;
    logic txv_r, txv_nxt;
    logic [7:0] txb_r, txb_nxt;
    logic pre_r, pre_nxt;
    logic [7:0] set_v;
    logic [7:0] keep_v;

    // Register bus answers come straight from flops
    assign bus.rdata = rdata_r;
    assign bus.rvalid = rvalid_r;
    assign bus.data_req = data_req_r;
    assign bus.event_irq = irq_r;
    assign tx_byte_valid_o = txv_r;
    assign tx_byte_o = txb_r;
    assign tx_preamble_o = pre_r;
    assign mode_o = st_r;

    // Control, data byte and flag next values
    always_comb
    begin
        st_nxt = st_r;
        mask_nxt = mask_r;
        data_nxt = data_r;
        full_nxt = full_r;
        started_nxt = started_r;
        cfg3_nxt = cfg3_r;
        cfg4_nxt = cfg4_r;
        rdata_nxt = rdata_r;
        txv_nxt = 1'b0;
        txb_nxt = txb_r;
        keep_v = 8'hff;
        set_v = 8'h00;
        set_v[5:0] = modem_status_i & ~prev_r;
        // Reads first, so a read and an arrival in one cycle both succeed
        if (bus.rd)
        begin
            case (bus.addr)
                ADDR_EVENT_MASK: rdata_nxt = mask_r;
                ADDR_EVENT_FLAGS: rdata_nxt = flags_r;
                ADDR_DATA_BYTE:
                begin
                    rdata_nxt = data_r;
                    if (st_r == RDP_RX)
                        full_nxt = 1'b0;
                end
                ADDR_MODEM_CFG3: rdata_nxt = cfg3_r;
                ADDR_MODEM_CFG4: rdata_nxt = cfg4_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
        // Received byte lands in the shared register
        if (rx_byte_valid_i && st_r == RDP_RX)
        begin
            if (full_nxt)
            begin
                st_nxt = RDP_RX_OVERFLOW;
                set_v[FLAG_RX_OVERFLOW] = 1'b1;
                set_v[FLAG_PACKET_DONE] = 1'b1;
            end
            else
            begin
                data_nxt = rx_byte_i;
                full_nxt = 1'b1;
            end
        end
        // Modem asks for the next byte to send
        if (tx_byte_req_i && st_r == RDP_TX)
        begin
            if (full_r)
            begin
                txv_nxt = 1'b1;
                txb_nxt = data_r;
                full_nxt = 1'b0;
            end
            else if (started_r)
            begin
                st_nxt = RDP_TX_UNDERFLOW;
                set_v[FLAG_TX_UNDERFLOW] = 1'b1;
                set_v[FLAG_PACKET_DONE] = 1'b1;
            end
            // Otherwise nothing written yet: modem keeps sending preamble
        end
        // Writes last, so a go-idle strobe wins over any modem event
        if (bus.wr)
        begin
            case (bus.addr)
                ADDR_EVENT_MASK: mask_nxt = bus.wdata;
                ADDR_EVENT_FLAGS: keep_v = bus.wdata;
                ADDR_DATA_BYTE:
                begin
                    // Ignored outside transmit, so early data is dropped
                    if (st_r == RDP_TX && !full_r)
                    begin
                        data_nxt = bus.wdata;
                        full_nxt = 1'b1;
                        started_nxt = 1'b1;
                    end
                end
                ADDR_STROBE:
                begin
                    if (bus.wdata == STROBE_GO_IDLE)
                    begin
                        st_nxt = RDP_IDLE;
                        full_nxt = 1'b0;
                        started_nxt = 1'b0;
                    end
                    else if (bus.wdata == STROBE_TRANSMIT && st_r == RDP_IDLE)
                    begin
                        st_nxt = RDP_TX;
                        full_nxt = 1'b0;
                        started_nxt = 1'b0;
                    end
                    else if (bus.wdata == STROBE_RECEIVE && st_r == RDP_IDLE)
                    begin
                        st_nxt = RDP_RX;
                        full_nxt = 1'b0;
                    end
                end
                ADDR_MODEM_CFG3: cfg3_nxt = bus.wdata;
                ADDR_MODEM_CFG4: cfg4_nxt = bus.wdata;
                default: ;
            endcase
        end
        // Hardware set ORed after the clear so it is never lost
        flags_nxt = (flags_r & keep_v) | set_v;
        // Request follows the next fill state so a mover never acts twice
        data_req_nxt = (st_nxt == RDP_TX && !full_nxt) ||
                       (st_nxt == RDP_RX && full_nxt);
        irq_nxt = |(flags_nxt & mask_nxt);
        pre_nxt = (st_nxt == RDP_TX) && !started_nxt;
    end

    // No retention across deep sleep is needed; only reset defines it
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            st_r <= RDP_IDLE;
            flags_r <= RST_EVENT_FLAGS;
            mask_r <= RST_EVENT_MASK;
            data_r <= RST_DATA_BYTE;
            full_r <= 1'b0;
            started_r <= 1'b0;
            cfg3_r <= RST_MODEM_CFG3;
            cfg4_r <= RST_MODEM_CFG4;
            prev_r <= 6'h00;
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            data_req_r <= 1'b0;
            irq_r <= 1'b0;
            txv_r <= 1'b0;
            txb_r <= 8'h00;
            pre_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            data_r <= data_nxt;
            full_r <= full_nxt;
            started_r <= started_nxt;
            cfg3_r <= cfg3_nxt;
            cfg4_r <= cfg4_nxt;
            prev_r <= modem_status_i;
            rdata_r <= rdata_nxt;
            rvalid_r <= bus.rd;
            data_req_r <= data_req_nxt;
            irq_r <= irq_nxt;
            txv_r <= txv_nxt;
            txb_r <= txb_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Timing: the system clock stands in for the reference frequency
    logic [RATE_FRAC_BITS-1:0] acc_r, acc_nxt;
    logic [RATE_FRAC_BITS:0] rate_inc;
    logic [RATE_FRAC_BITS:0] rate_sum;
    logic sym_r, sym_nxt;
    logic [8:0] bw_cnt_r, bw_cnt_nxt;
    logic [8:0] bw_limit;
    logic flt_r, flt_nxt;

    assign symbol_tick_o = sym_r;
    assign filter_tick_o = flt_r;

    // Carry out of a 28-bit accumulator gives ref*(256+M)*2^E/2^28
    always_comb
    begin
        rate_inc = (RATE_FRAC_BITS+1)'(RATE_MANT_BASE + {1'b0, cfg3_r})
                   << cfg4_r[RATE_EXP_MSB:RATE_EXP_LSB];
        rate_sum = {1'b0, acc_r} + rate_inc;
        acc_nxt = rate_sum[RATE_FRAC_BITS-1:0];
        sym_nxt = rate_sum[RATE_FRAC_BITS];
        // Period of 8*(4+M)*2^E reference cycles, at most 448
        bw_limit = 9'(((BW_MANT_BASE + 9'(cfg4_r[BW_MANT_MSB:BW_MANT_LSB]))
                   << BW_DIV_SHIFT) << cfg4_r[BW_EXP_MSB:BW_EXP_LSB])
                   - 9'h001;
        // Compare with >= so a shrinking period never lets the count run off
        if (bw_cnt_r >= bw_limit)
        begin
            bw_cnt_nxt = 9'h000;
            flt_nxt = 1'b1;
        end
        else
        begin
            bw_cnt_nxt = bw_cnt_r + 9'h001;
            flt_nxt = 1'b0;
        end
    end

    // Timing registers
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            acc_r <= '0;
            sym_r <= 1'b0;
            bw_cnt_r <= 9'h000;
            flt_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            sym_r <= sym_nxt;
            bw_cnt_r <= bw_cnt_nxt;
            flt_r <= flt_nxt;
        end
    end
endmodule : rdp_radio_port
`default_nettype wire

// ===== tb_radio_irq_and_data_port.sv
/*
  Self-checking bench joining the CPU end and the radio end.
  Assumes rdp_if, both ends and the checker are compiled first.
*/
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
    mismatches++; $display("Error %s exp %h got %h", nm, e, a); end end
module tb_radio_irq_and_data_port import rdp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, cv = 1'b0, cw = 1'b0, tv = 1'b0;
    logic rr = 1'b0, rxv = 1'b0, tq = 1'b0;
    logic [7:0] ca = 8'h00, cd = 8'h00, td = 8'h00, rxb = 8'h00, r, b;
    logic [5:0] ms = 6'h00;
    logic cr, rv, tr, rxvo, irq, txv, pre, st, ft;
    logic [7:0] rd_o, rxd, txb;
    rdp_mode_t mode;
    int mismatches = 0, n_compared = 0, cyc = 0, wn, mask_m, flags_m;
    logic [7:0] q[$];

    rdp_if bus_if ();
    rdp_radio_port rdp_radio_port_inst (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .bus(bus_if.dev), .modem_status_i(ms),
        .rx_byte_valid_i(rxv), .rx_byte_i(rxb), .tx_byte_req_i(tq),
        .tx_byte_valid_o(txv), .tx_byte_o(txb), .tx_preamble_o(pre),
        .mode_o(mode), .symbol_tick_o(st), .filter_tick_o(ft));
    rdp_cpu_port rdp_cpu_port_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .bus(bus_if.cpu), .cmd_valid_i(cv), .cmd_ready_o(cr),
        .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
        .resp_valid_o(rv), .resp_data_o(rd_o), .tx_valid_i(tv),
        .tx_ready_o(tr), .tx_data_i(td), .rx_valid_o(rxvo),
        .rx_ready_i(rr), .rx_data_o(rxd), .radio_irq_o(irq));
    rdp_bus_asserts rdp_bus_asserts_inst (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
        .rvalid(bus_if.rvalid), .data_req(bus_if.data_req),
        .event_irq(bus_if.event_irq));

    always #5 mclk_i = ~mclk_i;

    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // Waits for a level seen high at an edge; wn counts the edges
    task automatic wait_hi(ref logic s);
        wn = 1;
        @(posedge mclk_i);
        while (s !== 1'b1 && wn < 300)
        begin
            @(posedge mclk_i);
            wn++;
        end
        `CHK("wait", 1'b1, s)
    endtask : wait_hi

    task automatic pulse(input bit tx);
        if (tx)
            tq <= 1'b1;
        else
            rxv <= 1'b1;
        @(posedge mclk_i);
        tq <= 1'b0;
        rxv <= 1'b0;
        @(posedge mclk_i);
    endtask : pulse

    // One command; a read leaves its answer in r
    task automatic cmd(input logic w, input logic [7:0] a, d);
        cv <= 1'b1;
        cw <= w;
        ca <= a;
        cd <= d;
        wait_hi(cr);
        cv <= 1'b0;
        if (!w)
        begin
            wait_hi(rv);
            r = rd_o;
        end
        repeat (2) @(posedge mclk_i);
    endtask : cmd

    task automatic rdchk(input logic [7:0] a, e);
        cmd(1'b0, a, 8'h00);
        `CHK("register", e, r)
    endtask : rdchk

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        void'($urandom(32'hfc7a));
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rdchk(ADDR_EVENT_MASK, RST_EVENT_MASK);
        rdchk(ADDR_EVENT_FLAGS, RST_EVENT_FLAGS);
        rdchk(8'h00, 8'h00);
        mask_m = $urandom % 256;
        cmd(1'b1, ADDR_EVENT_MASK, mask_m[7:0]);
        rdchk(ADDR_EVENT_MASK, mask_m[7:0]);
        // Each status rise sets its own flag; irq follows the mask
        flags_m = 0;
        for (int i = 0; i < 6; i++)
        begin
            ms[i] <= 1'b1;
            repeat (3) @(posedge mclk_i);
            flags_m |= 1 << i;
            rdchk(ADDR_EVENT_FLAGS, flags_m[7:0]);
            `CHK("irq", ((flags_m & mask_m) != 0), irq)
        end
        cmd(1'b1, ADDR_EVENT_FLAGS, 8'h0f);
        rdchk(ADDR_EVENT_FLAGS, 8'h0f);
        cmd(1'b1, ADDR_EVENT_FLAGS, 8'h00);
        rdchk(ADDR_EVENT_FLAGS, 8'h00);
        ms <= 6'h00;
        $display("test flags done");
        // Transmit: early request keeps preamble, then bytes, underflow
        cmd(1'b1, ADDR_STROBE, STROBE_TRANSMIT);
        pulse(1);
        `CHK("preamble", 1'b1, pre)
        rdchk(ADDR_EVENT_FLAGS, 8'h00);
        tv <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            b = $urandom % 256;
            td <= b;
            q.push_back(b);
            wait_hi(tr);
        end
        tv <= 1'b0;
        repeat (3)
        begin
            repeat (6) @(posedge mclk_i);
            pulse(1);
            b = q.pop_front();
            `CHK("tx valid", 1'b1, txv)
            `CHK("tx byte", b, txb)
        end
        pulse(1);
        rdchk(ADDR_EVENT_FLAGS, 8'h90);
        `CHK("mode", RDP_TX_UNDERFLOW, mode)
        cmd(1'b1, ADDR_STROBE, STROBE_GO_IDLE);
        `CHK("mode", RDP_IDLE, mode)
        cmd(1'b1, ADDR_EVENT_FLAGS, 8'h00);
        $display("test transmit done");
        // Receive with the consumer stalled until the radio overflows
        cmd(1'b1, ADDR_STROBE, STROBE_RECEIVE);
        for (int i = 0; i < 4; i++)
        begin
            rxb <= i[7:0] + 8'ha0;
            pulse(0);
            repeat (8) @(posedge mclk_i);
        end
        rdchk(ADDR_EVENT_FLAGS, 8'h50);
        `CHK("mode", RDP_RX_OVERFLOW, mode)
        rr <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wait_hi(rxvo);
            `CHK("rx byte", i[7:0] + 8'ha0, rxd)
        end
        cmd(1'b1, ADDR_STROBE, STROBE_GO_IDLE);
        cmd(1'b1, ADDR_EVENT_FLAGS, 8'h00);
        // Reads free the data byte, so a drained stream never overflows
        cmd(1'b1, ADDR_STROBE, STROBE_RECEIVE);
        for (int i = 0; i < 4; i++)
        begin
            b = $urandom % 256;
            rxb <= b;
            pulse(0);
            wait_hi(rxvo);
            `CHK("rx byte", b, rxd)
        end
        rdchk(ADDR_EVENT_FLAGS, 8'h00);
        cmd(1'b1, ADDR_STROBE, STROBE_GO_IDLE);
        $display("test receive done");
        // Filter exponent 1 mantissa 3, rate exponent 15 mantissa 0
        cmd(1'b1, ADDR_MODEM_CFG3, 8'h00);
        cmd(1'b1, ADDR_MODEM_CFG4, 8'h7f);
        wait_hi(ft);
        wait_hi(ft);
        `CHK("filter period", 8 * (4 + 3) * (1 << 1), wn)
        wait_hi(st);
        wait_hi(st);
        `CHK("symbol period", (1 << 28) / (256 << 15), wn)
        $display("test timing done");
        finish_test();
    end
endmodule : tb_radio_irq_and_data_port
`default_nettype wire
